//--- logic/capture_compare_defs.svh
// Purpose: Constants for the sixteen channel capture/compare unit
// Assumes: Included by the time base and the capture/compare unit modules, not by the package or interface
// Notes:   Offsets are none; only field values and timing counts
`ifndef CAPTURE_COMPARE_DEFS_SVH
`define CAPTURE_COMPARE_DEFS_SVH
`define CC_CHANNELS       16
`define CC_WIDTH          16
`define CC_STAGGER_CYCLES 3'h7
`define CC_TIMER_RESET    16'h0000
`define CC_RELOAD_RESET   16'h0000
`define CC_REG_RESET      16'h0000
`define CC_SRC_PRESCALE   2'h0
`define CC_SRC_EXT_OVF    2'h1
`define CC_SRC_EXT_COUNT  2'h2
`endif

//--- logic/capture_compare_pkg.sv
// Purpose: Types of the capture/compare unit
// Assumes: Nothing
// Notes:   Mode codes are local choices of this unit
package capture_compare_pkg;
   typedef enum logic [2:0] {
      MODE_CAPTURE = 3'h0,
      MODE_CMP_IRQ = 3'h1,
      MODE_CMP_TGL = 3'h2,
      MODE_CMP_ONCE = 3'h3,
      MODE_CMP_SETRST = 3'h4,
      MODE_CMP_DOUBLE = 3'h5,
      MODE_OFF = 3'h6
   } cc_mode_t;
   typedef enum logic [1:0] {
      EDGE_RISE = 2'h1,
      EDGE_FALL = 2'h2,
      EDGE_BOTH = 2'h3
   } cc_edge_t;
   typedef enum logic [1:0] {
      TB_IDLE = 2'h1,
      TB_RUN  = 2'h2
   } tb_state_t;
endpackage

//--- logic/time_base_if.sv
// Purpose: Carries one time base state to the channel array
// Assumes: Single clock
// Notes:   Overflow is a one-cycle pulse
`timescale 1ns/1ns
interface time_base_if;
   logic [15:0] count;
   logic        ovf;
   logic        tick;
   modport src (output count, output ovf, output tick);
   modport dst (input count, input ovf, input tick);
endinterface

//--- logic/time_base.sv
// Purpose: One reloadable 16-bit time base
// Assumes: Tick sources are synchronous one-cycle pulses
// Notes:   Counts up; reloads on overflow
`timescale 1ns/1ns
`include "capture_compare_defs.svh"
module time_base (
   input  wire logic        i_clock,      // System clock
   input  wire logic        i_rst,        // Async reset, high
   input  wire logic        i_run,        // Timer enable
   input  wire logic [1:0]  i_src,        // Count source select
   input  wire logic [2:0]  i_prescale,   // Divide by 2**n
   input  wire logic        i_ext_ovf,    // External timer overflow pulse
   input  wire logic        i_ext_count,  // External count pulse
   input  wire logic [15:0] i_reload,     // Reload value
   time_base_if.src         tb            // Count state out
);
   logic [7:0]  pre_q;
   logic        pre_tick;
   logic        tick;
   logic [15:0] count_q;
   logic        ovf_q;
   // ****************************************
   // Prescaler and source select
   // ****************************************
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         pre_q <= 8'h00;
      end else begin
         pre_q <= pre_q + 8'h01;
      end
   end
   assign pre_tick = (i_prescale == 3'h0) ? 1'b1
                   : (pre_q & ((8'h01 << i_prescale) - 8'h01)) == 8'h00;
   always_comb begin
      case (i_src)
         `CC_SRC_PRESCALE:  tick = pre_tick;
         `CC_SRC_EXT_OVF:   tick = i_ext_ovf;
         `CC_SRC_EXT_COUNT: tick = i_ext_count;
         default:           tick = 1'b0;
      endcase
   end
   // ****************************************
   // Counter with reload
   // ****************************************
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         count_q <= `CC_TIMER_RESET;
         ovf_q   <= 1'b0;
      end else begin
         ovf_q <= 1'b0;
         if (i_run && tick) begin
            if (count_q == 16'hffff) begin
               count_q <= i_reload;
               ovf_q   <= 1'b1;
            end else begin
               count_q <= count_q + 16'h0001;
            end
         end
      end
   end
   assign tb.count = count_q;
   assign tb.ovf   = ovf_q;
   assign tb.tick  = i_run & tick;
   tick_reload_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_run && tick && count_q == 16'hffff) |=> (count_q == $past(i_reload) && ovf_q))
      else $error("Timer did not reload on overflow");
   count_up_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_run && tick && count_q != 16'hffff) |=> count_q == $past(count_q) + 16'h0001)
      else $error("Timer did not advance");
   hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
      !(i_run && tick) |=> $stable(count_q))
      else $error("Timer moved without tick");
endmodule

//--- logic/capture_compare_unit.sv
// Overview of operation
// - Sixteen channels, one-cycle resolution, eight cycles when staggered.
// - Two independent 16-bit timers with their own reload registers.
// - Timer clock from prescaled system clock or external timer overflow.
// - External count input can advance a timer.
// - Sixteen registers, each assignable to either timer, capture or compare.
// - Each register owns one pin: capture input or compare output.
// - Capture latches the assigned timer on a qualifying pin event.
// - Each capture raises that register's interrupt request.
// - Capture edge selectable: rising, falling or both.
// - Compare registers match continuously and act per selected mode.
// - Mode 0: interrupt on every match, no pin action.
// - Mode 1: pin toggles on every match.
// - Mode 2: interrupt on match, at most once per period.
// - Mode 3: pin high on match, low on overflow, once per period.
// - Double mode: channel pair toggles one pin on either match.
// - Single event option stops a compare register after one match.
//
// Purpose: Sixteen channel capture/compare unit with two time bases
// Assumes: Pins and external pulses synchronous to i_clock
// Notes:   Double mode pairs channel n with n+8; pin is that of channel n
`timescale 1ns/1ns
`include "capture_compare_defs.svh"
module capture_compare_unit (
   input  wire logic          i_clock,          // System clock
   input  wire logic          i_rst,            // Async reset, high
   input  wire logic          i_stagger,        // Staggered operation
   input  wire logic [1:0]    i_run,            // Timer enables
   input  wire logic [3:0]    i_src,            // Count source, 2 bits per timer
   input  wire logic [5:0]    i_prescale,       // Prescale, 3 bits per timer
   input  wire logic          i_ext_ovf,        // External timer overflow pulse
   input  wire logic          i_ext_count,      // External count pulse
   input  wire logic [15:0]   i_reload0,        // First time base reload
   input  wire logic [15:0]   i_reload1,        // Second time base reload
   input  wire logic [47:0]   i_mode,           // Mode, 3 bits per channel
   input  wire logic [31:0]   i_edge,           // Capture edge, 2 bits per channel
   input  wire logic [15:0]   i_timer_sel,      // Timer select per channel
   input  wire logic [15:0]   i_single,         // Single event option
   input  wire logic [15:0]   i_wr,             // Register write strobes
   input  wire logic [15:0]   i_wdata,          // Register write data
   input  wire logic [15:0]   i_pin,            // Pin input levels
   output logic      [15:0]   o_pin,            // Pin output levels
   output logic      [15:0]   o_pin_oe_n,       // Pin output enable, low drives
   output logic      [255:0]  o_value,          // Channel registers, 16 per channel
   output logic      [15:0]   o_irq,            // Per-channel request pulses
   output logic      [15:0]   o_cnt0,           // First time base count
   output logic      [15:0]   o_cnt1            // Second time base count
);
   time_base_if tb0 ();
   time_base_if tb1 ();
   logic [2:0]  slot_q;
   logic [15:0] pin_prev_q;
   logic [15:0] reg_q [16];
   logic [15:0] fired_q;
   logic [15:0] done_q;
   logic [15:0] pin_q;
   logic [15:0] irq_q;
   logic [15:0] hit_all;
   logic [15:0] pend_q;
   logic [1:0]  fresh_q;
   // ****************************************
   // Time bases
   // ****************************************
   time_base u_tb0 (
      .i_clock     (i_clock),
      .i_rst       (i_rst),
      .i_run       (i_run[0]),
      .i_src       (i_src[1:0]),
      .i_prescale  (i_prescale[2:0]),
      .i_ext_ovf   (i_ext_ovf),
      .i_ext_count (i_ext_count),
      .i_reload    (i_reload0),
      .tb          (tb0)
   );
   time_base u_tb1 (
      .i_clock     (i_clock),
      .i_rst       (i_rst),
      .i_run       (i_run[1]),
      .i_src       (i_src[3:2]),
      .i_prescale  (i_prescale[5:3]),
      .i_ext_ovf   (i_ext_ovf),
      .i_ext_count (i_ext_count),
      .i_reload    (i_reload1),
      .tb          (tb1)
   );
   // ****************************************
   // Stagger slot: channel pair served every eighth cycle
   // ****************************************
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         slot_q <= 3'h0;
      end else begin
         slot_q <= (slot_q == `CC_STAGGER_CYCLES) ? 3'h0 : slot_q + 3'h1;
      end
   end
   // ****************************************
   // Pin history for edge detection
   // ****************************************
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         pin_prev_q <= 16'h0000;
      end else begin
         pin_prev_q <= i_pin;
      end
   end
   // ****************************************
   // New count flags: one match per timer value
   // ****************************************
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         fresh_q <= 2'h0;
      end else begin
         fresh_q <= {tb1.tick, tb0.tick};
      end
   end
   // ****************************************
   // Channel array
   // ****************************************
   for (genvar n = 0; n < `CC_CHANNELS; n++) begin : g_ch
      capture_compare_pkg::cc_mode_t mode;
      capture_compare_pkg::cc_edge_t edge_sel;
      logic [15:0] cnt;
      logic        ovf;
      logic        active;
      logic        rise;
      logic        fall;
      logic        cap;
      logic        cap_raw;
      logic        hit_raw;
      logic        hit;
      logic        cmp_mode;
      assign mode     = capture_compare_pkg::cc_mode_t'(i_mode[3*n +: 3]);
      assign edge_sel = capture_compare_pkg::cc_edge_t'(i_edge[2*n +: 2]);
      assign cnt      = i_timer_sel[n] ? tb1.count : tb0.count;
      assign ovf      = i_timer_sel[n] ? tb1.ovf : tb0.ovf;
      assign active   = !i_stagger || (slot_q == 3'(n % 8));
      assign rise     = i_pin[n] && !pin_prev_q[n];
      assign fall     = !i_pin[n] && pin_prev_q[n];
      assign cmp_mode = (mode != capture_compare_pkg::MODE_CAPTURE) &&
                        (mode != capture_compare_pkg::MODE_OFF);
      assign cap_raw  = (mode == capture_compare_pkg::MODE_CAPTURE) &&
                        ((rise && edge_sel[0]) || (fall && edge_sel[1]));
      assign hit_raw  = cmp_mode && (reg_q[n] == cnt) &&
                        (i_timer_sel[n] ? fresh_q[1] : fresh_q[0]);
      // Event seen outside its stagger slot waits for the slot
      assign cap      = (mode == capture_compare_pkg::MODE_CAPTURE) && active &&
                        !done_q[n] && (cap_raw || pend_q[n]);
      assign hit      = cmp_mode && active && !done_q[n] && (hit_raw || pend_q[n]);
      assign hit_all[n] = hit;
      always_ff @(posedge i_clock or posedge i_rst) begin
         if (i_rst) begin
            reg_q[n] <= `CC_REG_RESET;
         end else if (cap) begin
            reg_q[n] <= cnt;
         end else if (i_wr[n]) begin
            reg_q[n] <= i_wdata;
         end
      end
      always_ff @(posedge i_clock or posedge i_rst) begin
         if (i_rst) begin
            pend_q[n] <= 1'b0;
         end else if (active) begin
            pend_q[n] <= 1'b0;
         end else if (cap_raw || hit_raw) begin
            pend_q[n] <= 1'b1;
         end
      end
      always_ff @(posedge i_clock or posedge i_rst) begin
         if (i_rst) begin
            fired_q[n] <= 1'b0;
            done_q[n]  <= 1'b0;
            irq_q[n]   <= 1'b0;
         end else begin
            irq_q[n] <= cap;
            if (ovf) begin
               fired_q[n] <= 1'b0;
            end
            if (i_wr[n] || !i_single[n]) begin
               done_q[n] <= 1'b0;
            end
            if (hit) begin
               case (mode)
                  capture_compare_pkg::MODE_CMP_IRQ:    irq_q[n] <= 1'b1;
                  capture_compare_pkg::MODE_CMP_ONCE: begin
                     irq_q[n] <= !fired_q[n];
                     fired_q[n] <= 1'b1;
                  end
                  capture_compare_pkg::MODE_CMP_SETRST: begin
                     irq_q[n] <= !fired_q[n];
                     fired_q[n] <= 1'b1;
                  end
                  default: irq_q[n] <= 1'b1;
               endcase
               if (i_single[n]) begin
                  done_q[n] <= 1'b1;
               end
            end
         end
      end
      if (n < 8) begin : g_pin
         logic hit_pair;
         assign hit_pair = (hit_all[n+8] &&
                            i_mode[3*(n+8) +: 3] == 3'(capture_compare_pkg::MODE_CMP_DOUBLE));
         always_ff @(posedge i_clock or posedge i_rst) begin
            if (i_rst) begin
               pin_q[n] <= 1'b0;
            end else if ((hit && (mode == capture_compare_pkg::MODE_CMP_TGL ||
                          mode == capture_compare_pkg::MODE_CMP_DOUBLE)) || hit_pair) begin
               pin_q[n] <= !pin_q[n];
            end else if (hit && mode == capture_compare_pkg::MODE_CMP_SETRST && !fired_q[n]) begin
               pin_q[n] <= 1'b1;
            end else if (ovf && mode == capture_compare_pkg::MODE_CMP_SETRST) begin
               pin_q[n] <= 1'b0;
            end
         end
      end else begin : g_pin
         always_ff @(posedge i_clock or posedge i_rst) begin
            if (i_rst) begin
               pin_q[n] <= 1'b0;
            end else if (hit && mode == capture_compare_pkg::MODE_CMP_TGL) begin
               pin_q[n] <= !pin_q[n];
            end else if (hit && mode == capture_compare_pkg::MODE_CMP_SETRST && !fired_q[n]) begin
               pin_q[n] <= 1'b1;
            end else if (ovf && mode == capture_compare_pkg::MODE_CMP_SETRST) begin
               pin_q[n] <= 1'b0;
            end
         end
      end
      // Pin drives only in pin-acting compare modes
      assign o_pin_oe_n[n] = !(mode == capture_compare_pkg::MODE_CMP_TGL ||
                               mode == capture_compare_pkg::MODE_CMP_SETRST ||
                               mode == capture_compare_pkg::MODE_CMP_DOUBLE);
      assign o_value[16*n +: 16] = reg_q[n];
      capture_irq_a: assert property (@(posedge i_clock) disable iff (i_rst)
         cap |=> irq_q[n] && reg_q[n] == $past(cnt))
         else $error("Capture lost value or request");
      once_irq_a: assert property (@(posedge i_clock) disable iff (i_rst)
         (hit && mode == capture_compare_pkg::MODE_CMP_ONCE && fired_q[n] && !ovf) |=> !irq_q[n])
         else $error("Second request in one period");
      toggle_pin_a: assert property (@(posedge i_clock) disable iff (i_rst)
         (hit && mode == capture_compare_pkg::MODE_CMP_TGL) |=> pin_q[n] != $past(pin_q[n]))
         else $error("Pin did not toggle");
      irq_mode0_a: assert property (@(posedge i_clock) disable iff (i_rst)
         (hit && mode == capture_compare_pkg::MODE_CMP_IRQ) |=> irq_q[n])
         else $error("Match request missing");
      setrst_low_a: assert property (@(posedge i_clock) disable iff (i_rst)
         (ovf && !hit && mode == capture_compare_pkg::MODE_CMP_SETRST) |=> !pin_q[n])
         else $error("Pin not reset on overflow");
      stagger_wait_a: assert property (@(posedge i_clock) disable iff (i_rst)
         (pend_q[n] && active && !done_q[n] && mode == capture_compare_pkg::MODE_CAPTURE)
         |=> irq_q[n])
         else $error("Held capture not served");
      single_stop_a: assert property (@(posedge i_clock) disable iff (i_rst)
         (hit && i_single[n] && !i_wr[n]) ##1 (i_single[n] && !i_wr[n]) |-> !hit)
         else $error("Single event repeated");
   end
   assign o_pin  = pin_q;
   assign o_irq  = irq_q;
   assign o_cnt0 = tb0.count;
   assign o_cnt1 = tb1.count;
endmodule

//--- dv/pin_model.sv
// Purpose: Far-side model of the channel pins and external timer pulses
// Assumes: Requests arrive a fixed delay after the rising clock edge
// Notes:   A pin the unit drives reads back as the unit's own level
`timescale 1ns/1ns
module pin_model (
   input  wire logic        i_clock,     // System clock
   input  wire logic [15:0] i_lvl,       // Levels the far side applies
   input  wire logic [15:0] i_out,       // Unit pin levels
   input  wire logic [15:0] i_oe_n,      // Unit drives when low
   output logic      [15:0] o_wire,      // Resolved pin levels
   output logic             o_ext_ovf,   // External overflow pulse
   output logic             o_ext_count  // External count pulse
);
   // ****************************************
   // Pin resolution and external pulses
   // ****************************************
   assign o_wire = (i_oe_n & i_lvl) | (~i_oe_n & i_out);
   initial begin
      o_ext_ovf = 1'b0;
      o_ext_count = 1'b0;
   end
   // One-cycle pulse on the count or the overflow line
   task automatic pulse(input logic sel);
      @(posedge i_clock);
      #5;
      if (sel) o_ext_count = 1'b1;
      else o_ext_ovf = 1'b1;
      @(posedge i_clock);
      #5;
      o_ext_ovf = 1'b0;
      o_ext_count = 1'b0;
   endtask
endmodule

//--- dv/tb_top.sv
// Purpose: Self-checking bench of the capture/compare unit
// Assumes: First time base reloads to 16'hffe0, a 32-cycle period
// Notes:   Inputs change 5 ns after the rising edge
`timescale 1ns/1ns
module tb_top;
   logic           clk, rst, stag, prv;
   logic [1:0]     run;
   logic [3:0]     src;
   logic [5:0]     pre;
   logic [15:0]    rl0, rl1, tsel, sgl, wstb, wd, lvl;
   logic [47:0]    mode;
   logic [31:0]    edg;
   wire  [15:0]    pin_w, opin, oen, irq, cnt0, cnt1;
   wire            ovf, ecnt;
   wire  [255:0]   val;
   int             n_fail, n_compared, n_irq, n_tog, mon;
   pin_model u_pm (.i_clock(clk), .i_lvl(lvl), .i_out(opin), .i_oe_n(oen),
      .o_wire(pin_w), .o_ext_ovf(ovf), .o_ext_count(ecnt));
   capture_compare_unit u_dut (.i_clock(clk), .i_rst(rst), .i_stagger(stag),
      .i_run(run), .i_src(src), .i_prescale(pre), .i_ext_ovf(ovf),
      .i_ext_count(ecnt), .i_reload0(rl0), .i_reload1(rl1), .i_mode(mode),
      .i_edge(edg), .i_timer_sel(tsel), .i_single(sgl), .i_wr(wstb),
      .i_wdata(wd), .i_pin(pin_w), .o_pin(opin), .o_pin_oe_n(oen),
      .o_value(val), .o_irq(irq), .o_cnt0(cnt0), .o_cnt1(cnt1));
   // ****************************************
   // Clock, monitor and access tasks
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (irq[mon] === 1'b1) n_irq++;
      if (opin[mon] !== prv) n_tog++;
      prv = opin[mon];
   end
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s exp %h got %h", what, e, g);
      end
   endtask
   task end_sim;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask
   task automatic wait_cnt(input logic [15:0] v, input int lim);
      int k;
      k = 0;
      while (cnt0 !== v) begin
         cyc(1);
         k++;
         if (k > lim) begin
            n_fail++;
            $display("wrong value count exp %h got %h", v, cnt0);
            end_sim;
         end
      end
   endtask
   task automatic wr(input int ch, input logic [15:0] v);
      wd = v;
      wstb[ch] = 1'b1;
      cyc(1);
      wstb = 16'h0000;
   endtask
   task automatic cap(input int ch, input logic lv, input logic hit);
      logic [15:0] rec, d;
      logic        seen;
      rec = tsel[ch] ? cnt1 : cnt0;
      lvl[ch] = lv;
      seen = 1'b0;
      for (int k = 0; k < 12 && !seen; k++) begin
         cyc(1);
         seen = (irq[ch] === 1'b1);
      end
      chk("capture irq", {15'h0, hit}, {15'h0, seen});
      if (seen) begin
         d = val[16*ch +: 16] - rec;
         chk("capture value", 16'h0001, {15'h0, d <= (stag ? 16'h0007 : 16'h0000)});
         cyc(1);
         chk("irq width", 16'h0000, {15'h0, irq[ch]});
      end
   endtask
   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      capture_compare_pkg::cc_edge_t ek[3];
      capture_compare_pkg::cc_mode_t md[6];
      int cs[6], c2[6], ei[6], et[6], ee[6], sg[6], c;
      logic [15:0] a;
      ek = '{capture_compare_pkg::EDGE_RISE, capture_compare_pkg::EDGE_FALL,
             capture_compare_pkg::EDGE_BOTH};
      md = '{capture_compare_pkg::MODE_CMP_IRQ, capture_compare_pkg::MODE_CMP_TGL,
             capture_compare_pkg::MODE_CMP_ONCE, capture_compare_pkg::MODE_CMP_SETRST,
             capture_compare_pkg::MODE_CMP_DOUBLE, capture_compare_pkg::MODE_CMP_TGL};
      cs = '{5, 6, 8, 9, 7, 10};
      c2 = '{5, 6, 8, 9, 15, 11};
      ei = '{2, -1, 1, -1, -1, -1};
      et = '{0, 2, 0, 1, 2, 1};
      ee = '{0, 0, 0, 0, 1, 1};
      sg = '{0, 0, 0, 0, 0, 1};
      rst = 1'b1; stag = 1'b0; run = 2'b11; src = 4'hc; pre = 6'h00; rl0 = 16'hffe0;
      rl1 = 16'h0000; mode = {16{capture_compare_pkg::MODE_OFF}}; edg = 32'h0;
      tsel = 16'h0002; sgl = 16'h0000; wstb = 16'h0000; wd = 16'h0000; lvl = 16'h0000;
      n_fail = 0; n_compared = 0; n_irq = 0; n_tog = 0; mon = 0; prv = 1'b0;
      repeat (12) @(posedge clk);
      #5;
      rst = 1'b0;
      chk("reset irq", 16'h0000, irq);
      chk("reset value", 16'h0000, val[15:0]);
      chk("reset count", 16'h0000, cnt1);
      $display("test reset done");
      for (int s = 1; s < 3; s++) begin
         src[3:2] = s[1:0];
         a = cnt1;
         repeat (3) u_pm.pulse(s == 2);
         cyc(2);
         chk("ext ticks", a + 16'h0003, cnt1);
      end
      src[3:2] = 2'h0;
      pre[5:3] = 3'h2;
      a = cnt1;
      cyc(32);
      chk("prescaled ticks", 16'h0008, cnt1 - a);
      src[3:2] = 2'h3;
      $display("test sources done");
      wait_cnt(16'hffff, 70000);
      cyc(1);
      chk("reload", 16'hffe0, cnt0);
      $display("test reload done");
      for (int i = 0; i < 4; i++) begin
         c = (i == 3) ? 1 : 2 + i;
         mode[3*c +: 3] = capture_compare_pkg::MODE_CAPTURE;
         edg[2*c +: 2] = (i == 3) ? capture_compare_pkg::EDGE_RISE : ek[i];
         cyc(1);
         chk("capture oe_n", 16'h0001, {15'h0, oen[c]});
         cap(c, 1'b1, i != 1);
         cap(c, 1'b0, i == 1 || i == 2);
      end
      $display("test capture done");
      mode[45 +: 3] = capture_compare_pkg::MODE_CMP_DOUBLE;
      for (int i = 0; i < 6; i++) begin
         wait_cnt(16'hffe2, 100);
         mode[3*cs[i] +: 3] = md[i];
         sgl[cs[i]] = sg[i][0];
         mon = cs[i];
         wr(cs[i], 16'hffe8);
         n_irq = 0;
         n_tog = 0;
         prv = opin[cs[i]];
         wait_cnt(16'hffee, 100);
         wr(c2[i], 16'hfff6);
         wait_cnt(16'hfffc, 100);
         if (ei[i] >= 0) chk("compare irqs", 16'(ei[i]), 16'(n_irq));
         chk("pin toggles", 16'(et[i]), 16'(n_tog));
         if (et[i] > 0) chk("compare oe_n", 16'h0000, {15'h0, oen[cs[i]]});
         wait_cnt(16'hffec, 100);
         chk("pin level", 16'(ee[i]), {15'h0, opin[cs[i]]});
      end
      $display("test compare done");
      stag = 1'b1;
      mode[36 +: 3] = capture_compare_pkg::MODE_CAPTURE;
      edg[24 +: 2] = capture_compare_pkg::EDGE_RISE;
      wait_cnt(16'hffe2, 100);
      cap(12, 1'b1, 1'b1);
      stag = 1'b0;
      $display("test stagger done");
      end_sim;
   end
endmodule
